// ---- common/ccr_pkg.sv ----
// Package for the cursor colour and TV test register bank
package ccr_pkg;

	// Register byte offsets
	localparam logic [11:0] CCR_OFF_CURSOR_BG = 12'h170;
	localparam logic [11:0] CCR_OFF_CURSOR_FG = 12'h174;
	localparam logic [11:0] CCR_OFF_TV_SIZE = 12'h178;
	localparam logic [11:0] CCR_OFF_TEST_CTRL = 12'h17c;

	// Writable bits per register; all other bits are reserved and read zero
	localparam logic [31:0] CCR_MASK_COLOR = 32'h00ffffff;
	localparam logic [31:0] CCR_MASK_TV_SIZE = 32'h000fffff;
	localparam logic [31:0] CCR_MASK_TEST_CTRL = 32'h0000000c;

	// Reset values
	localparam logic [31:0] CCR_RST_COLOR = 32'h00000000;
	localparam logic [31:0] CCR_RST_TV_SIZE = 32'h00000000;
	localparam logic [31:0] CCR_RST_TEST_CTRL = 32'h00000000;

	// Bit 0 of the printed layout is the word's msb; these are vector positions
	localparam int CCR_RED_LSB = 16;
	localparam int CCR_GREEN_LSB = 8;
	localparam int CCR_BLUE_LSB = 0;
	localparam int CCR_ANALOG_LSB = 18;
	localparam int CCR_SYSTEM_LSB = 16;
	localparam int CCR_HTEST_LSB = 8;
	localparam int CCR_VTEST_LSB = 0;
	localparam int CCR_VTEST_EN_BIT = 3;
	localparam int CCR_HTEST_EN_BIT = 2;

	// Analog output modes
	typedef enum logic [1:0] {
		CCR_OUT_RGB,
		CCR_OUT_COMPOSITE,
		CCR_OUT_SVIDEO_COMPOSITE
	} ccr_analog_t;

	// TV systems
	typedef enum logic [1:0] {
		CCR_SYS_PAL_BDGHN,
		CCR_SYS_PAL_M,
		CCR_SYS_NTSC,
		CCR_SYS_RESERVED
	} ccr_tv_system_t;

	// Flip a printed bit number into a vector position
	function automatic int ccr_bitpos(input int printed);
		return 31 - printed;
	endfunction

	// Byte-lane merge of APB write data under a writable-bit mask
	function automatic logic [31:0] ccr_merge(input logic [31:0] old_val,
		input logic [31:0] wdata, input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] lanes;
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
		return (old_val & ~lanes) | (wdata & lanes);
	endfunction

endpackage

// ---- hdl/ccr_color_split.sv ----
// Splits a stored cursor colour word into its red, green and blue bytes
`timescale 1ns/100ps
`default_nettype none

module ccr_color_split
	import ccr_pkg::*;
(
	input wire logic [31:0] color_word,
	output logic [7:0] red,
	output logic [7:0] green,
	output logic [7:0] blue
);

	// Only RGB 8:8:8 exists, so the split is fixed wiring
	always_comb begin
		red = color_word[CCR_RED_LSB +: 8];
		green = color_word[CCR_GREEN_LSB +: 8];
		blue = color_word[CCR_BLUE_LSB +: 8];
	end

endmodule
`default_nettype wire

// ---- hdl/ccr_tv_timing_sel.sv ----
// Chooses between normal and test TV totals and decodes output mode
`timescale 1ns/100ps
`default_nettype none

module ccr_tv_timing_sel
	import ccr_pkg::*;
#(
	parameter int H_W = 11,
	parameter int V_W = 10
) (
	input wire logic [31:0] tv_size,
	input wire logic [31:0] test_ctrl,
	input wire logic [H_W-1:0] normal_h_total,
	input wire logic [V_W-1:0] normal_v_total,
	output logic [H_W-1:0] h_total,
	output logic [V_W-1:0] v_total,
	output logic h_test_active,
	output logic v_test_active,
	output ccr_analog_t analog_mode,
	output ccr_tv_system_t tv_system
);

	logic [1:0] analog_code;

	always_comb begin
		h_test_active = test_ctrl[CCR_HTEST_EN_BIT];
		v_test_active = test_ctrl[CCR_VTEST_EN_BIT];
		// Test totals only reach the timing while their enable is set
		h_total = h_test_active ? H_W'(tv_size[CCR_HTEST_LSB +: 8]) : normal_h_total;
		v_total = v_test_active ? V_W'(tv_size[CCR_VTEST_LSB +: 8]) : normal_v_total;
		analog_code = tv_size[CCR_ANALOG_LSB +: 2];
		case (analog_code)
			2'h2: analog_mode = CCR_OUT_COMPOSITE;
			2'h3: analog_mode = CCR_OUT_SVIDEO_COMPOSITE;
			default: analog_mode = CCR_OUT_RGB;
		endcase
		tv_system = ccr_tv_system_t'(tv_size[CCR_SYSTEM_LSB +: 2]);
	end

endmodule
`default_nettype wire

// ---- hdl/ccr_regs.sv ----
// APB register bank for cursor colours, TV output mode and TV test sizes
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module ccr_regs
	import ccr_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int H_W = 11,
	parameter int V_W = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [H_W-1:0] normal_h_total,
	input wire logic [V_W-1:0] normal_v_total,
	output logic [7:0] bg_red,
	output logic [7:0] bg_green,
	output logic [7:0] bg_blue,
	output logic [7:0] fg_red,
	output logic [7:0] fg_green,
	output logic [7:0] fg_blue,
	output logic [H_W-1:0] tv_h_total,
	output logic [V_W-1:0] tv_v_total,
	output logic tv_h_test_active,
	output logic tv_v_test_active,
	output logic tv_encoder_on,
	output logic composite_en,
	output logic svideo_en,
	output logic [1:0] tv_system
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [31:0] cursor_background_color;
		logic [31:0] cursor_foreground_color;
		logic [31:0] tv_output_and_test_size;
		logic [31:0] video_post_test_control;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] bg_red;
		logic [7:0] bg_green;
		logic [7:0] bg_blue;
		logic [7:0] fg_red;
		logic [7:0] fg_green;
		logic [7:0] fg_blue;
		logic [H_W-1:0] h_total;
		logic [V_W-1:0] v_total;
		logic h_test;
		logic v_test;
		logic enc_on;
		logic comp_en;
		logic svid_en;
		logic [1:0] system;
	} ccr_state_t;

	ccr_state_t state_reg;
	ccr_state_t state_next;

	////////////////////////////////////////////////////////////////////////////
	// Field decode of the current register contents

	logic [7:0] bg_r;
	logic [7:0] bg_g;
	logic [7:0] bg_b;
	logic [7:0] fg_r;
	logic [7:0] fg_g;
	logic [7:0] fg_b;
	logic [H_W-1:0] sel_h_total;
	logic [V_W-1:0] sel_v_total;
	logic sel_h_test;
	logic sel_v_test;
	ccr_analog_t sel_analog;
	ccr_tv_system_t sel_system;

	ccr_color_split u_bg_split (
		.color_word(state_reg.cursor_background_color),
		.red(bg_r),
		.green(bg_g),
		.blue(bg_b)
	);

	ccr_color_split u_fg_split (
		.color_word(state_reg.cursor_foreground_color),
		.red(fg_r),
		.green(fg_g),
		.blue(fg_b)
	);

	ccr_tv_timing_sel #(
		.H_W(H_W),
		.V_W(V_W)
	) u_tv_sel (
		.tv_size(state_reg.tv_output_and_test_size),
		.test_ctrl(state_reg.video_post_test_control),
		.normal_h_total(normal_h_total),
		.normal_v_total(normal_v_total),
		.h_total(sel_h_total),
		.v_total(sel_v_total),
		.h_test_active(sel_h_test),
		.v_test_active(sel_v_test),
		.analog_mode(sel_analog),
		.tv_system(sel_system)
	);

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	logic [11:0] word_addr;
	logic hit_bg;
	logic hit_fg;
	logic hit_tv;
	logic hit_tc;
	logic mapped;
	logic setup_phase;
	logic access_done;

	always_comb begin
		word_addr = 12'(paddr);
		hit_bg = (word_addr == CCR_OFF_CURSOR_BG);
		hit_fg = (word_addr == CCR_OFF_CURSOR_FG);
		hit_tv = (word_addr == CCR_OFF_TV_SIZE);
		hit_tc = (word_addr == CCR_OFF_TEST_CTRL);
		mapped = hit_bg | hit_fg | hit_tv | hit_tc;
		setup_phase = psel & ~penable;
		// Answer is prepared in setup so every output stays a flop
		access_done = psel & penable & state_reg.pready;
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		state_next = state_reg;
		state_next.pready = setup_phase;
		state_next.pslverr = setup_phase & ~mapped;
		if (setup_phase) begin
			if (pwrite || !mapped) begin
				state_next.prdata = 32'h00000000;
			end else if (hit_bg) begin
				state_next.prdata = state_reg.cursor_background_color;
			end else if (hit_fg) begin
				state_next.prdata = state_reg.cursor_foreground_color;
			end else if (hit_tv) begin
				state_next.prdata = state_reg.tv_output_and_test_size;
			end else begin
				state_next.prdata = state_reg.video_post_test_control;
			end
		end
		// Writes land only on the completing edge; unmapped ones are dropped
		if (access_done && pwrite) begin
			if (hit_bg) begin
				state_next.cursor_background_color = ccr_merge(
					state_reg.cursor_background_color, pwdata, pstrb, CCR_MASK_COLOR);
			end
			if (hit_fg) begin
				state_next.cursor_foreground_color = ccr_merge(
					state_reg.cursor_foreground_color, pwdata, pstrb, CCR_MASK_COLOR);
			end
			if (hit_tv) begin
				state_next.tv_output_and_test_size = ccr_merge(
					state_reg.tv_output_and_test_size, pwdata, pstrb, CCR_MASK_TV_SIZE);
			end
			if (hit_tc) begin
				state_next.video_post_test_control = ccr_merge(
					state_reg.video_post_test_control, pwdata, pstrb, CCR_MASK_TEST_CTRL);
			end
		end
		// Outputs lag the register contents by one cycle
		state_next.bg_red = bg_r;
		state_next.bg_green = bg_g;
		state_next.bg_blue = bg_b;
		state_next.fg_red = fg_r;
		state_next.fg_green = fg_g;
		state_next.fg_blue = fg_b;
		state_next.h_total = sel_h_total;
		state_next.v_total = sel_v_total;
		state_next.h_test = sel_h_test;
		state_next.v_test = sel_v_test;
		state_next.enc_on = (sel_analog != CCR_OUT_RGB);
		state_next.comp_en = (sel_analog != CCR_OUT_RGB);
		state_next.svid_en = (sel_analog == CCR_OUT_SVIDEO_COMPOSITE);
		state_next.system = sel_system;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.cursor_background_color <= CCR_RST_COLOR;
			state_reg.cursor_foreground_color <= CCR_RST_COLOR;
			state_reg.tv_output_and_test_size <= CCR_RST_TV_SIZE;
			state_reg.video_post_test_control <= CCR_RST_TEST_CTRL;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		prdata = state_reg.prdata;
		pready = state_reg.pready;
		pslverr = state_reg.pslverr;
		bg_red = state_reg.bg_red;
		bg_green = state_reg.bg_green;
		bg_blue = state_reg.bg_blue;
		fg_red = state_reg.fg_red;
		fg_green = state_reg.fg_green;
		fg_blue = state_reg.fg_blue;
		tv_h_total = state_reg.h_total;
		tv_v_total = state_reg.v_total;
		tv_h_test_active = state_reg.h_test;
		tv_v_test_active = state_reg.v_test;
		tv_encoder_on = state_reg.enc_on;
		composite_en = state_reg.comp_en;
		svideo_en = state_reg.svid_en;
		tv_system = state_reg.system;
	end

endmodule
`default_nettype wire

// ---- dv/ccr_regs_checker.sv ----
// Concurrent checks on the register bank ports
`timescale 1ns/100ps
`default_nettype none
module ccr_regs_checker
	import ccr_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int H_W = 11,
	parameter int V_W = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [H_W-1:0] normal_h_total,
	input wire logic [V_W-1:0] normal_v_total,
	input wire logic [7:0] bg_red,
	input wire logic [7:0] bg_green,
	input wire logic [7:0] bg_blue,
	input wire logic [H_W-1:0] tv_h_total,
	input wire logic [V_W-1:0] tv_v_total,
	input wire logic tv_h_test_active,
	input wire logic tv_v_test_active,
	input wire logic tv_encoder_on,
	input wire logic composite_en,
	input wire logic svideo_en,
	input wire logic [1:0] tv_system
);
	// Only full-word writes, so every lane is known
	wire wr = psel && penable && pready && pwrite && pstrb == 4'hf;
	wire wr_bg = wr && paddr[11:0] == CCR_OFF_CURSOR_BG;
	wire wr_tv = wr && paddr[11:0] == CCR_OFF_TV_SIZE;
	wire wr_tc = wr && paddr[11:0] == CCR_OFF_TEST_CTRL;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	property p_bg;
		wr_bg |-> ##2 {bg_red, bg_green, bg_blue} == $past(pwdata[23:0], 2);
	endproperty
	a_bg: assert property (p_bg) else $error("bg colour bytes wrong");
	property p_htest;
		wr_tv ##2 tv_h_test_active |-> tv_h_total == $past(pwdata[15:8], 2);
	endproperty
	a_htest: assert property (p_htest) else $error("h test total wrong");
	property p_vtest;
		wr_tv ##2 tv_v_test_active |-> tv_v_total == $past(pwdata[7:0], 2);
	endproperty
	a_vtest: assert property (p_vtest) else $error("v test total wrong");
	property p_hnorm;
		$past(presetn) && !tv_h_test_active |-> tv_h_total == $past(normal_h_total);
	endproperty
	a_hnorm: assert property (p_hnorm) else $error("h normal total wrong");
	property p_vnorm;
		$past(presetn) && !tv_v_test_active |-> tv_v_total == $past(normal_v_total);
	endproperty
	a_vnorm: assert property (p_vnorm) else $error("v normal total wrong");
	property p_en;
		wr_tc |-> ##2 {tv_h_test_active, tv_v_test_active} == {$past(pwdata[2], 2), $past(pwdata[3], 2)};
	endproperty
	a_en: assert property (p_en) else $error("test enables wrong");
	property p_mode;
		wr_tv |-> ##2 {tv_encoder_on, svideo_en, tv_system}
			== {$past(pwdata[19], 2), $past(&pwdata[19:18], 2), $past(pwdata[17:16], 2)};
	endproperty
	a_mode: assert property (p_mode) else $error("output mode wrong");
	property p_comp;
		$past(presetn) |-> composite_en == tv_encoder_on && (!svideo_en || composite_en);
	endproperty
	a_comp: assert property (p_comp) else $error("composite enable wrong");
endmodule
`default_nettype wire

// ---- dv/ccr_regs_tb_top.sv ----
// Self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
module ccr_regs_tb_top
	import ccr_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed, d;
	logic [3:0] pstrb;
	logic [10:0] nh, tvh;
	logic [9:0] nv, tvv;
	logic [7:0] br, bgr, bb, fr, fgr, fb;
	logic hta, vta, enc, comp, sv;
	logic [1:0] sys, k;
	logic [32:0] q[$];
	int errors, compares;
	ccr_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .normal_h_total(nh), .normal_v_total(nv),
		.bg_red(br), .bg_green(bgr), .bg_blue(bb), .fg_red(fr), .fg_green(fgr),
		.fg_blue(fb), .tv_h_total(tvh), .tv_v_total(tvv), .tv_h_test_active(hta),
		.tv_v_test_active(vta), .tv_encoder_on(enc), .composite_en(comp),
		.svideo_en(sv), .tv_system(sys));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Expected {pslverr, prdata} noted before the transfer starts
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		input logic [3:0] s, input logic [32:0] e);
		int n;
		q.push_back(e);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		// Ready is sampled at the rising edge that completes the access
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			$display("CHECK FAILED pready expected 1 seen %b", pready);
			print_verdict();
		end
		psel <= 0;
		penable <= 0;
	endtask
	task automatic vid();
		@(posedge pclk);
		@(negedge pclk);
	endtask
	// Response taken at the same edge that completes the access
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1)
			chk("apb", q.pop_front(), {pslverr, prdata});
	end
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{errors, compares} = '0;
		seed = 32'h5c56;
		nh = 11'h35a;
		nv = 10'h1c7;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 4; i++)
			apb(0, CCR_OFF_CURSOR_BG + 12'(4 * i), 0, 4'hf, 0);
		apb(0, 12'h180, 0, 4'hf, {1'b1, 32'h0});
		apb(1, 12'h16c, '1, 4'hf, {1'b1, 32'h0});
		$display("Test reset and unmapped done");
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			d = xs(seed);
			apb(1, CCR_OFF_CURSOR_BG, seed, 4'hf, 0);
			apb(1, CCR_OFF_CURSOR_FG, d, 4'hf, 0);
			vid();
			chk("bg", seed[23:0], {br, bgr, bb});
			chk("fg", d[23:0], {fr, fgr, fb});
			// Reserved lane plus green lane only
			apb(1, CCR_OFF_CURSOR_BG, ~seed, 4'b1010, 0);
			apb(0, CCR_OFF_CURSOR_BG, 0, 4'hf, {9'h0, seed[23:16], ~seed[15:8], seed[7:0]});
			seed = d;
		end
		$display("Test cursor colours done");
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			k = 2'(i);
			d = {seed[31:20], k, ~k, seed[15:4], k, seed[1:0]};
			nh <= seed[30:20];
			nv <= seed[29:20];
			apb(1, CCR_OFF_TV_SIZE, d, 4'hf, 0);
			apb(1, CCR_OFF_TEST_CTRL, d, 4'hf, 0);
			vid();
			chk("mode", {d[19], d[19], &d[19:18], d[17:16]}, {enc, comp, sv, sys});
			chk("htot", d[2] ? 11'(d[15:8]) : nh, tvh);
			chk("vtot", d[3] ? 10'(d[7:0]) : nv, tvv);
			chk("act", {d[2], d[3]}, {hta, vta});
			apb(0, CCR_OFF_TV_SIZE, 0, 4'hf, {1'b0, d & CCR_MASK_TV_SIZE});
			apb(0, CCR_OFF_TEST_CTRL, 0, 4'hf, {1'b0, d & CCR_MASK_TEST_CTRL});
		end
		$display("Test TV mode and totals done");
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		apb(0, CCR_OFF_CURSOR_BG, 0, 4'hf, 0);
		vid();
		chk("rst_bg", 24'h0, {br, bgr, bb});
		chk("rst_fg", 24'h0, {fr, fgr, fb});
		chk("rst_act", 2'b00, {hta, vta});
		chk("rst_htot", nh, tvh);
		$display("Test second reset done");
		print_verdict();
	end
endmodule
bind ccr_regs ccr_regs_checker #(.ADDR_W(ADDR_W), .H_W(H_W), .V_W(V_W)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
	.normal_h_total(normal_h_total), .normal_v_total(normal_v_total), .bg_red(bg_red),
	.bg_green(bg_green), .bg_blue(bg_blue), .tv_h_total(tv_h_total),
	.tv_v_total(tv_v_total), .tv_h_test_active(tv_h_test_active),
	.tv_v_test_active(tv_v_test_active), .tv_encoder_on(tv_encoder_on),
	.composite_en(composite_en), .svideo_en(svideo_en), .tv_system(tv_system));
`default_nettype wire
